// ### src/osd_running_indication_a.sv
// Output-stage self-diagnostic sequencer with its APB register file.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// Function
// - Depth select 0..3 chooses checks
// - Higher depth includes all lower checks
// - Depth 3 requests full three-phase ground check
// - Input with function code 20 triggers
// - Trigger on runs checks showing running indication
// - Stop key, trigger off or e-stop abort
// - Detected error shows and holds fault indication
// - Enter shows code, up/down browse codes
// - Stop key or reset input clears fault
// - Codes 1..6 are power switch faults
// - Codes 7..9 are phase-to-phase shorts
// - Codes 10..12 are phase ground faults
// - Codes 13..15 are open output phases
module osd_running_indication_a #(
    parameter int HIST_DEPTH = 4
) (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        CE_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic [7:0]  MF_INPUT_IN,
    input  wire logic        EMERGENCY_STOP_INPUT_IN,
    input  wire logic        KEY_STOP_RESET_IN,
    input  wire logic        KEY_ENTER_IN,
    input  wire logic        KEY_UP_IN,
    input  wire logic        KEY_DOWN_IN,
    output logic             CHECK_REQ_OUT,
    output logic      [3:0]  CHECK_CODE_OUT,
    output logic             CHECK_FULL_GROUND_OUT,
    input  wire logic        CHECK_ACK_IN,
    input  wire logic        CHECK_FAIL_IN,
    output logic             RUNNING_INDICATION_A_OUT,
    output logic             RUNNING_INDICATION_A_FAULT_INDICATION_OUT,
    output logic             CODE_SHOWN_OUT,
    output logic      [3:0]  SHOWN_CODE_OUT,
    output logic             MENU_RETURN_OUT,
    output logic             IRQ_OUT
);

    localparam int HW = $clog2(HIST_DEPTH);

    // Next check code after the given one at the given depth, zero at end.
    function automatic logic [3:0] next_code(input logic [3:0] code,
                                             input logic [1:0] depth);
        logic [3:0] nxt;
        nxt = code + 4'h1;
        if (code == osd_pkg::FAULT_W_LOWER_SWITCH) begin
            nxt = (depth >= osd_pkg::DEPTH_PHASE) ?
                  osd_pkg::FAULT_SHORT_U_W : osd_pkg::FAULT_GROUND_U;
        end else if (code == osd_pkg::FAULT_SHORT_V_W) begin
            nxt = osd_pkg::FAULT_OPEN_U;
        end else if (code == osd_pkg::FAULT_OPEN_W) begin
            nxt = osd_pkg::FAULT_GROUND_U;
        end else if (code == osd_pkg::FAULT_GROUND_W) begin
            nxt = osd_pkg::CODE_NONE;
        end
        return nxt;
    endfunction : next_code

    // Configuration and state.
    logic [1:0]                 running_indication_a_depth_select;
    logic [4:0]                 fsel [8];
    logic [2:0]                 irq_stat;
    logic [2:0]                 irq_mask;
    osd_pkg::osd_state_type     state;
    logic [3:0]                 cur_code;
    logic [3:0]                 hist [HIST_DEPTH];
    logic [HW-1:0]              hist_wr;
    logic [HW:0]                hist_cnt;
    logic [HW-1:0]              browse;
    logic                       shown;
    logic                       menu_ret;

    // Synchronised pins.
    logic [7:0] mf_q;
    logic [4:0] key_q;
    logic [4:0] key_rise;

    osd_sync #(.W(8)) u_mf_sync (
        .clk_in   (REF_CLK_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .d_in     (MF_INPUT_IN),
        .q_out    (mf_q),
        .rise_out (),
        .fall_out ()
    );

    osd_sync #(.W(5)) u_key_sync (
        .clk_in   (REF_CLK_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .d_in     ({EMERGENCY_STOP_INPUT_IN, KEY_DOWN_IN, KEY_UP_IN,
                    KEY_ENTER_IN, KEY_STOP_RESET_IN}),
        .q_out    (key_q),
        .rise_out (key_rise),
        .fall_out ()
    );

    // Trigger and reset-function levels gathered over all eight inputs.
    logic [7:0] trig_vec;
    logic [7:0] rst_vec;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            trig_vec[i] = mf_q[i] && (fsel[i] == osd_pkg::FUNC_RUNNING_INDICATION_A);
            rst_vec[i]  = mf_q[i] && (fsel[i] == osd_pkg::FUNC_RESET);
        end
    end

    logic trig_lvl;
    logic trig_prev;
    logic rstf_lvl;
    logic rstf_prev;
    assign trig_lvl = |trig_vec;
    assign rstf_lvl = |rst_vec;

    // Decoded events.
    wire stop_key  = key_rise[0];
    wire enter_key = key_rise[1];
    wire up_key    = key_rise[2];
    wire down_key  = key_rise[3];
    wire estop     = key_q[4];
    wire trig_on   = trig_lvl && !trig_prev;
    wire rstf_on   = rstf_lvl && !rstf_prev;
    wire running   = (state == osd_pkg::ST_ISSUE) ||
                     (state == osd_pkg::ST_WAIT);
    wire start_ok  = (state == osd_pkg::ST_IDLE) && trig_on && !estop &&
                     (running_indication_a_depth_select != osd_pkg::DEPTH_OFF);
    wire abort_now = running && (stop_key || !trig_lvl || estop);
    wire step_ack  = (state == osd_pkg::ST_WAIT) && CHECK_ACK_IN;
    wire step_fail = step_ack && CHECK_FAIL_IN;
    wire [3:0] step_next = next_code(cur_code, running_indication_a_depth_select);
    wire seq_done  = step_ack && !CHECK_FAIL_IN &&
                     (step_next == osd_pkg::CODE_NONE);
    wire fault_clr = (state == osd_pkg::ST_FAULT) &&
                     (stop_key || rstf_on);

    // APB decode; every access completes with no wait states.
    wire        apb_acc = PSEL_IN && PENABLE_IN;
    wire        apb_wr  = apb_acc && PWRITE_IN;
    wire        sel_ctl = PADDR_IN == osd_pkg::CTRL_OFS;
    wire        sel_flo = PADDR_IN == osd_pkg::FUNC_LO_OFS;
    wire        sel_fhi = PADDR_IN == osd_pkg::FUNC_HI_OFS;
    wire        sel_sts = PADDR_IN == osd_pkg::STATUS_OFS;
    wire        sel_irs = PADDR_IN == osd_pkg::IRQ_STAT_OFS;
    wire        sel_irm = PADDR_IN == osd_pkg::IRQ_MASK_OFS;
    wire        sel_hst = PADDR_IN == osd_pkg::HIST_OFS;
    wire        mapped  = sel_ctl | sel_flo | sel_fhi | sel_sts |
                          sel_irs | sel_irm | sel_hst;
    wire [2:0]  irq_set = {step_fail, abort_now, seq_done};
    wire [2:0]  irq_w1c = (apb_wr && sel_irs && CE_IN) ?
                          PWDATA_IN[2:0] : 3'h0;
    wire [3:0]  last_code = (hist_cnt == '0) ? osd_pkg::CODE_NONE :
                            hist[hist_wr - HW'(1)];

    // Read data assembled from the register fields.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (sel_ctl) begin
            rd_mux[osd_pkg::DEPTH_LSB +: osd_pkg::DEPTH_W] = running_indication_a_depth_select;
        end
        for (int i = 0; i < 4; i++) begin
            if (sel_flo) begin
                rd_mux[i*osd_pkg::FSEL_PITCH +: osd_pkg::FSEL_W] = fsel[i];
            end
            if (sel_fhi) begin
                rd_mux[i*osd_pkg::FSEL_PITCH +: osd_pkg::FSEL_W] = fsel[i+4];
            end
        end
        if (sel_sts) begin
            rd_mux[osd_pkg::ST_STATE +: 2] = state;
            rd_mux[osd_pkg::ST_RUN]        = running;
            rd_mux[osd_pkg::ST_FLT]        = state == osd_pkg::ST_FAULT;
            rd_mux[osd_pkg::ST_SHOW]       = shown;
            rd_mux[osd_pkg::ST_CODE +: 4]  = hist[browse];
            rd_mux[osd_pkg::ST_LAST +: 4]  = last_code;
        end
        if (sel_irs) begin
            rd_mux[osd_pkg::IRQ_W-1:0] = irq_stat;
        end
        if (sel_irm) begin
            rd_mux[osd_pkg::IRQ_W-1:0] = irq_mask;
        end
        if (sel_hst) begin
            rd_mux[HW:0] = hist_cnt;
        end
    end

    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = apb_acc && !mapped;

    // Read data is registered at the setup edge for the access cycle.
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h0;
        end else if (CE_IN && PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            PRDATA_OUT <= rd_mux;
        end
    end

    // Software-written configuration.
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            running_indication_a_depth_select <= osd_pkg::DEPTH_RST;
            irq_mask          <= osd_pkg::MASK_RST;
            for (int i = 0; i < 7; i++) begin
                fsel[i] <= osd_pkg::FSEL_RST;
            end
            fsel[7] <= osd_pkg::FSEL8_RST;
        end else if (CE_IN && apb_wr) begin
            if (sel_ctl) begin
                running_indication_a_depth_select <= PWDATA_IN[1:0];
            end
            if (sel_irm) begin
                irq_mask <= PWDATA_IN[2:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (sel_flo) begin
                    fsel[i] <= PWDATA_IN[i*8 +: 5];
                end
                if (sel_fhi) begin
                    fsel[i+4] <= PWDATA_IN[i*8 +: 5];
                end
            end
        end
    end

    // Sticky interrupt bits; a new event wins over a same-cycle clear.
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            irq_stat <= 3'h0;
        end else if (CE_IN) begin
            irq_stat <= (irq_stat & ~irq_w1c) | irq_set;
        end
    end

    assign IRQ_OUT = |(irq_stat & irq_mask);

    // Diagnostic sequencer.
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            state     <= osd_pkg::ST_IDLE;
            cur_code  <= osd_pkg::CODE_NONE;
            trig_prev <= 1'b0;
            rstf_prev <= 1'b0;
            menu_ret  <= 1'b0;
        end else if (CE_IN) begin
            trig_prev <= trig_lvl;
            rstf_prev <= rstf_lvl;
            menu_ret  <= seq_done || abort_now || fault_clr;
            unique case (state)
                osd_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        cur_code <= osd_pkg::FAULT_U_UPPER_SWITCH;
                        state    <= osd_pkg::ST_ISSUE;
                    end
                end
                osd_pkg::ST_ISSUE: begin
                    if (abort_now) begin
                        state <= osd_pkg::ST_IDLE;
                    end else begin
                        state <= osd_pkg::ST_WAIT;
                    end
                end
                osd_pkg::ST_WAIT: begin
                    if (abort_now) begin
                        state <= osd_pkg::ST_IDLE;
                    end else if (step_fail) begin
                        state <= osd_pkg::ST_FAULT;
                    end else if (seq_done) begin
                        state <= osd_pkg::ST_IDLE;
                    end else if (step_ack) begin
                        cur_code <= step_next;
                        state    <= osd_pkg::ST_ISSUE;
                    end
                end
                osd_pkg::ST_FAULT: begin
                    if (fault_clr) begin
                        state <= osd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Fault record memory and keypad browsing of stored codes.
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            hist_wr  <= '0;
            hist_cnt <= '0;
            browse   <= '0;
            shown    <= 1'b0;
            for (int i = 0; i < HIST_DEPTH; i++) begin
                hist[i] <= osd_pkg::CODE_NONE;
            end
        end else if (CE_IN) begin
            if (step_fail) begin
                hist[hist_wr] <= cur_code;
                browse        <= hist_wr;
                hist_wr       <= hist_wr + HW'(1);
                if (hist_cnt != (HW+1)'(HIST_DEPTH)) begin
                    hist_cnt <= hist_cnt + (HW+1)'(1);
                end
            end
            if (state != osd_pkg::ST_FAULT) begin
                shown <= 1'b0;
            end else if (!fault_clr) begin
                if (enter_key) begin
                    shown <= 1'b1;
                end
                if (shown && up_key) begin
                    browse <= browse + HW'(1);
                end else if (shown && down_key) begin
                    browse <= browse - HW'(1);
                end
            end
        end
    end

    // Check request to the power stage, held until acknowledged or aborted.
    assign CHECK_REQ_OUT         = state == osd_pkg::ST_WAIT;
    assign CHECK_CODE_OUT        = cur_code;
    assign CHECK_FULL_GROUND_OUT =
        running_indication_a_depth_select == osd_pkg::DEPTH_FULL;

    // Keypad display indications; running replaced by fault on error.
    assign RUNNING_INDICATION_A_OUT  = running;
    assign RUNNING_INDICATION_A_FAULT_INDICATION_OUT = state == osd_pkg::ST_FAULT;
    assign CODE_SHOWN_OUT            = shown;
    assign SHOWN_CODE_OUT            = hist[browse];
    assign MENU_RETURN_OUT           = menu_ret;

endmodule : osd_running_indication_a

// ### src/osd_pkg.sv
// Constants shared by the output-stage self-diagnostic sequencer.
package osd_pkg;

    // APB register byte offsets.
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] FUNC_LO_OFS  = 8'h04;
    localparam logic [7:0] FUNC_HI_OFS  = 8'h08;
    localparam logic [7:0] STATUS_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] HIST_OFS     = 8'h18;

    // Field positions and widths.
    localparam int DEPTH_LSB  = 0;
    localparam int DEPTH_W    = 2;
    localparam int FSEL_W     = 5;
    localparam int FSEL_PITCH = 8;
    localparam int CODE_W     = 4;
    localparam int ST_STATE   = 0;
    localparam int ST_RUN     = 2;
    localparam int ST_FLT     = 3;
    localparam int ST_SHOW    = 4;
    localparam int ST_CODE    = 8;
    localparam int ST_LAST    = 12;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_ABORT  = 1;
    localparam int IRQ_FAULT  = 2;
    localparam int IRQ_W      = 3;

    // Reset values.
    localparam logic [1:0] DEPTH_RST = 2'h0;
    localparam logic [4:0] FSEL_RST  = 5'h00;
    localparam logic [4:0] FSEL8_RST = 5'h07;
    localparam logic [2:0] MASK_RST  = 3'h0;

    // Input function codes.
    localparam logic [4:0] FUNC_RUNNING_INDICATION_A  = 5'h14;
    localparam logic [4:0] FUNC_RESET = 5'h05;

    // Depth selections.
    localparam logic [1:0] DEPTH_OFF    = 2'h0;
    localparam logic [1:0] DEPTH_SWITCH = 2'h1;
    localparam logic [1:0] DEPTH_PHASE  = 2'h2;
    localparam logic [1:0] DEPTH_FULL   = 2'h3;

    // Fault codes, one per check step.
    localparam logic [3:0] FAULT_U_UPPER_SWITCH = 4'h1;
    localparam logic [3:0] FAULT_W_LOWER_SWITCH = 4'h6;
    localparam logic [3:0] FAULT_SHORT_U_W      = 4'h7;
    localparam logic [3:0] FAULT_SHORT_V_W      = 4'h9;
    localparam logic [3:0] FAULT_GROUND_U       = 4'ha;
    localparam logic [3:0] FAULT_GROUND_W       = 4'hc;
    localparam logic [3:0] FAULT_OPEN_U         = 4'hd;
    localparam logic [3:0] FAULT_OPEN_W         = 4'hf;
    localparam logic [3:0] CODE_NONE            = 4'h0;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10,
        ST_FAULT = 2'b11
    } osd_state_type;

endpackage : osd_pkg

// ### src/osd_sync.sv
// Two-stage synchroniser with edge detection for keypad and terminal pins.
`timescale 1ns/10ps
module osd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] fall_out
);

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // The first stage feeds only the second; edges use later stages.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta   <= '0;
            stable <= '0;
            prev   <= '0;
        end else if (ce_in) begin
            meta   <= d_in;
            stable <= meta;
            prev   <= stable;
        end
    end

    // Edges last one enabled cycle.
    assign q_out    = stable;
    assign rise_out = stable & ~prev;
    assign fall_out = ~stable & prev;

endmodule : osd_sync

// ### dv/osd_running_indication_a_assertions.sv
// Concurrent checks on the ports of the self-diagnostic sequencer.
`timescale 1ns/10ps
module osd_running_indication_a_checker (
    input wire logic       REF_CLK_IN,
    input wire logic       RST_IN,
    input wire logic       CE_IN,
    input wire logic       EMERGENCY_STOP_INPUT_IN,
    input wire logic       CHECK_REQ_OUT,
    input wire logic [3:0] CHECK_CODE_OUT,
    input wire logic       CHECK_ACK_IN,
    input wire logic       CHECK_FAIL_IN,
    input wire logic       RUNNING_INDICATION_A_OUT,
    input wire logic       RUNNING_INDICATION_A_FAULT_INDICATION_OUT,
    input wire logic       CODE_SHOWN_OUT,
    input wire logic       MENU_RETURN_OUT
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // Short names for the step handshake.
    wire logic run  = RUNNING_INDICATION_A_OUT;
    wire logic flt  = RUNNING_INDICATION_A_FAULT_INDICATION_OUT;
    wire logic req  = CHECK_REQ_OUT;
    wire logic take = req && CHECK_ACK_IN && CE_IN;
    wire logic last = CHECK_CODE_OUT == 4'hc;

    chk_code_stable: assert property (req && !CHECK_ACK_IN |=>
        !req || $stable(CHECK_CODE_OUT)) else $error("step code moved");
    chk_run_excl: assert property (!(run && flt))
        else $error("running and fault shown together");
    chk_fail_fault: assert property (take && CHECK_FAIL_IN |=>
        flt && !run) else $error("failed step did not raise fault");
    chk_pass_end: assert property (take && !CHECK_FAIL_IN && last |=>
        MENU_RETURN_OUT && !run) else $error("no return after last step");
    chk_next_step: assert property (take && !CHECK_FAIL_IN && !last
        |=> !req ##1 req) else $error("next step not issued");
    chk_first_code: assert property ($rose(run) |=>
        req && CHECK_CODE_OUT == 4'h1) else $error("first step wrong");
    chk_idle_quiet: assert property (!run |-> !req)
        else $error("step requested while not running");
    chk_estop_abort: assert property (run && EMERGENCY_STOP_INPUT_IN
        |-> ##[1:6] !run) else $error("stop input did not abort");
    chk_shown_fault: assert property ($rose(CODE_SHOWN_OUT) |-> flt)
        else $error("code shown outside fault");
    chk_menu_pulse: assert property (MENU_RETURN_OUT |=>
        !MENU_RETURN_OUT) else $error("menu return longer than a cycle");
endmodule : osd_running_indication_a_checker

bind osd_running_indication_a osd_running_indication_a_checker osd_running_indication_a_checker_inst (
    .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
    .EMERGENCY_STOP_INPUT_IN(EMERGENCY_STOP_INPUT_IN),
    .CHECK_REQ_OUT(CHECK_REQ_OUT), .CHECK_CODE_OUT(CHECK_CODE_OUT),
    .CHECK_ACK_IN(CHECK_ACK_IN), .CHECK_FAIL_IN(CHECK_FAIL_IN),
    .RUNNING_INDICATION_A_OUT(RUNNING_INDICATION_A_OUT),
    .RUNNING_INDICATION_A_FAULT_INDICATION_OUT(RUNNING_INDICATION_A_FAULT_INDICATION_OUT),
    .CODE_SHOWN_OUT(CODE_SHOWN_OUT), .MENU_RETURN_OUT(MENU_RETURN_OUT));

// ### dv/osd_stage_model.sv
// Behavioural power stage that answers each check step.
`timescale 1ns/10ps
module osd_stage_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       req_in,
    input  wire logic [3:0] code_in,
    input  wire logic [3:0] fail_code_in,
    input  wire logic [7:0] delay_in,
    output logic            ack_out,
    output logic            fail_out
);
    logic [7:0] wait_cnt;

    // Answer after delay_in cycles and fail only the commanded step.
    // Between answers the fail line toggles, so nothing may lean on it.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wait_cnt <= 8'h00;
            ack_out  <= 1'b0;
            fail_out <= 1'b0;
        end else if (req_in && !ack_out && wait_cnt == delay_in) begin
            ack_out  <= 1'b1;
            fail_out <= (code_in == fail_code_in);
        end else begin
            wait_cnt <= (req_in && !ack_out) ? wait_cnt + 8'h01 : 8'h00;
            ack_out  <= 1'b0;
            fail_out <= ~fail_out;
        end
    end
endmodule : osd_stage_model

// ### dv/tb_top.sv
// Self-checking bench for the output-stage self-diagnostic sequencer.
`timescale 1ns/10ps
module tb_top;
    logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, mf, delay;
    logic [31:0] pwdata, prdata, rd;
    logic        estop, req, full_gnd, ack, fail, run, flt, shown, menu;
    logic [3:0]  keys, code, shown_code, fail_code;
    logic        irq, err;
    logic [3:0]  seen[$], exp_q[$];
    int          err_total, samples_checked, cyc, menus;

    osd_running_indication_a #(.HIST_DEPTH(4)) osd_running_indication_a_inst (
        .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .MF_INPUT_IN(mf),
        .EMERGENCY_STOP_INPUT_IN(estop), .KEY_STOP_RESET_IN(keys[0]),
        .KEY_ENTER_IN(keys[1]), .KEY_UP_IN(keys[2]), .KEY_DOWN_IN(keys[3]),
        .CHECK_REQ_OUT(req), .CHECK_CODE_OUT(code),
        .CHECK_FULL_GROUND_OUT(full_gnd), .CHECK_ACK_IN(ack),
        .CHECK_FAIL_IN(fail), .RUNNING_INDICATION_A_OUT(run),
        .RUNNING_INDICATION_A_FAULT_INDICATION_OUT(flt), .CODE_SHOWN_OUT(shown),
        .SHOWN_CODE_OUT(shown_code), .MENU_RETURN_OUT(menu),
        .IRQ_OUT(irq));

    osd_stage_model osd_stage_model_inst (
        .clk_in(clk), .rst_in(rst), .req_in(req), .code_in(code),
        .fail_code_in(fail_code), .delay_in(delay), .ack_out(ack),
        .fail_out(fail));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Log accepted steps and menu returns; cut a hang short.
    always @(posedge clk) begin
        cyc++;
        if (req === 1'b1 && ack === 1'b1 && ce) seen.push_back(code);
        if (menu === 1'b1) menus++;
        if (cyc == 30000) begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Wait, bounded, for running (sel 0) or fault (sel 1) to reach v.
    task automatic wt(input int sel, input logic v, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge clk);
            if ((sel == 0 ? run : flt) === v) break;
        end
        check("state wait", {31'h0, n < lim}, 32'h1);
    endtask : wt

    // Keys are slow levels; hold long enough to pass the synchroniser.
    task automatic press(input int k);
        @(posedge clk);
        keys[k] <= 1'b1;
        repeat (6) @(posedge clk);
        keys[k] <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : press

    task automatic start(input int b);
        seen = {};
        @(posedge clk);
        mf[b] <= 1'b1;
    endtask : start

    task automatic t_regs();
        apb(0, osd_pkg::CTRL_OFS, 0);
        check("ctrl reset", rd, 32'h0);
        apb(0, osd_pkg::FUNC_HI_OFS, 0);
        check("func hi reset", rd, 32'h0700_0000);
        apb(0, osd_pkg::IRQ_MASK_OFS, 0);
        check("mask reset", rd, 32'h0);
        apb(0, 8'h1c, 0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        ce <= 1'b0;
        apb(1, osd_pkg::CTRL_OFS, 32'h3);
        ce <= 1'b1;
        apb(0, osd_pkg::CTRL_OFS, 0);
        check("frozen write", rd, 32'h0);
        $display("register test done");
    endtask : t_regs

    task automatic t_pass(input logic [1:0] d, input int b);
        int c;
        exp_q = {};
        for (c = 1; c <= 15; c++)
            if (d != 0 && (c <= 6 || (d > 1 && (c <= 9 || c >= 13))))
                exp_q.push_back(4'(c));
        if (d != 0) exp_q = {exp_q, 4'ha, 4'hb, 4'hc};
        apb(1, osd_pkg::CTRL_OFS, {30'h0, d});
        menus = 0;
        start(b);
        if (d == 0) repeat (30) @(negedge clk);
        else wt(0, 1, 20);
        wt(0, 0, 300);
        // The menu pulse is logged one edge after running falls.
        @(negedge clk);
        check("full ground", full_gnd, d == 2'h3);
        check("step count", seen.size(), exp_q.size());
        foreach (exp_q[i]) check("step code", seen[i], exp_q[i]);
        check("menu return", menus, d != 2'h0);
        apb(0, osd_pkg::IRQ_STAT_OFS, 0);
        check("done event", rd[0], d != 2'h0);
        check("masked irq", irq, 1'b0);
        apb(1, osd_pkg::IRQ_STAT_OFS, 32'h7);
        mf[b] <= 1'b0;
        repeat (6) @(posedge clk);
        $display("pass run test done");
    endtask : t_pass

    task automatic t_abort(input int k);
        delay <= 8'hc8;
        apb(1, osd_pkg::CTRL_OFS, 32'h3);
        start(0);
        wt(0, 1, 20);
        if (k == 0) press(0);
        else if (k == 1) mf[0] <= 1'b0;
        else estop <= 1'b1;
        wt(0, 0, 20);
        check("step dropped", req, 1'b0);
        check("no step taken", seen.size(), 0);
        apb(0, osd_pkg::IRQ_STAT_OFS, 0);
        check("abort event", rd[1], 1'b1);
        apb(1, osd_pkg::IRQ_STAT_OFS, 32'h7);
        estop <= 1'b0;
        mf <= 8'h00;
        delay <= 8'h00;
        repeat (6) @(posedge clk);
        $display("abort test done");
    endtask : t_abort

    task automatic t_fault(input logic [3:0] c, input logic by_rst);
        fail_code <= c;
        apb(1, osd_pkg::IRQ_MASK_OFS, 32'h4);
        start(0);
        wt(1, 1, 200);
        check("running off", run, 1'b0);
        check("stop step", seen[$], c);
        apb(0, osd_pkg::STATUS_OFS, 0);
        check("last code", rd[15:12], c);
        check("fault irq", irq, 1'b1);
        press(1);
        check("code shown", shown, 1'b1);
        check("shown code", shown_code, c);
        press(2);
        press(3);
        check("browse back", shown_code, c);
        if (by_rst) mf[1] <= 1'b1;
        else press(0);
        wt(1, 0, 20);
        apb(1, osd_pkg::IRQ_STAT_OFS, 32'h4);
        @(negedge clk);
        check("irq cleared", irq, 1'b0);
        mf <= 8'h00;
        fail_code <= 4'h0;
        repeat (6) @(posedge clk);
        $display("fault test done");
    endtask : t_fault

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Main sequence: reset, registers, runs, aborts, faults.
    initial begin
        {rst, ce, psel, penable, pwrite, estop} = 6'b110000;
        {paddr, mf, delay, keys, fail_code} = '0;
        pwdata = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        apb(1, osd_pkg::FUNC_LO_OFS, 32'h0000_0514);
        for (int d = 0; d < 4; d++) t_pass(2'(d), 0);
        apb(1, osd_pkg::FUNC_HI_OFS, 32'h1400_0000);
        t_pass(2'h1, 7);
        for (int k = 0; k < 3; k++) t_abort(k);
        t_fault(4'h6, 1'b0);
        t_fault(4'h9, 1'b1);
        t_fault(4'hc, 1'b0);
        t_fault(4'hf, 1'b1);
        conclude();
    end
endmodule : tb_top
